// ==== hdl/dspw_consts.vh ====
/*
 * Constants for the dual secondary pulse-width timers: register
 * offsets, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef DSPW_CONSTS_VH
`define DSPW_CONSTS_VH

// register byte addresses on the Avalon-MM slave (word aligned)
`define DSPW_ADDR_W           4
`define DSPW_OFS_FIRST_PERIOD 4'h0
`define DSPW_OFS_SECOND_PER   4'h4
`define DSPW_OFS_FIRST_ON     4'h8
`define DSPW_OFS_SECOND_ON    4'hC

// shared mode control register and its bit
`define DSPW_OFS_MODE_CTRL    4'h0
`define DSPW_MODE_CTRL_BASE   1'b1
`define DSPW_MODE_BIT         8

// reset values
`define DSPW_RST_PERIOD       8'hFF
`define DSPW_RST_ON_TIME      8'h00
`define DSPW_RST_MODE         1'b0

// timebase: one tick per two clock periods
`define DSPW_TICK_DIV         2

`endif

// ==== hdl/dspw_tick.v ====
/*
 * Timebase divider: one-cycle enable pulse every DSPW_TICK_DIV clocks.
 * Assumes one clock; restart realigns the pulse with a new cycle.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dspw_consts.vh"

module dspw_tick
(
    // clock and reset
    input  wire clk,
    input  wire nrst,
    // control
    input  wire restart,
    // timebase
    output reg  tick
);

    reg [0:0] phase;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            phase <= 1'b0;
            tick  <= 1'b0;
        end
        else if (restart)
        begin
            phase <= 1'b0;
            tick  <= 1'b0;
        end
        else
        begin
            phase <= phase + 1'b1;
            tick  <= (phase == 1'b1);
        end
    end

endmodule
`default_nettype wire

// ==== hdl/dspw_chan.v ====
/*
 * One pulse channel: 8-bit counter, pending on-time latched at the
 * start of each cycle. Assumes tick is a one-cycle enable and that
 * restart clears the counter. Counter counts 0..period, output high
 * while count < on-time, or always when on-time exceeds period.
 */
`timescale 1ns/1ps
`default_nettype none
`include "dspw_consts.vh"

module dspw_chan
(
    // clock and reset
    input  wire       clk,
    input  wire       nrst,
    // timebase and control
    input  wire       tick,
    input  wire       restart,
    input  wire       hold,
    input  wire       start,
    input  wire [7:0] period,
    input  wire [7:0] on_pending,
    // state
    output reg  [7:0] count,
    output reg        pulse
);

    reg  [7:0] on_live;
    reg        running;
    wire       wrap = (count == period);
    wire [7:0] next_count = wrap ? 8'h00 : count + 8'h01;
    // comparison uses the value that governs the cycle being entered
    wire [7:0] on_eff = (next_count == 8'h00) ? on_pending : on_live;

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            count   <= 8'h00;
            on_live <= `DSPW_RST_ON_TIME;
            running <= 1'b0;
            pulse   <= 1'b0;
        end
        else if (restart)
        begin
            count   <= 8'h00;
            running <= 1'b0;
            pulse   <= 1'b0;
        end
        else if (!running)
        begin
            // waits for the offset point in offset mode
            if (start)
            begin
                running <= 1'b1;
                count   <= 8'h00;
                on_live <= on_pending;
                pulse   <= (on_pending > period) || (on_pending != 8'h00);
            end
        end
        else if (tick && !hold)
        begin
            count <= next_count;
            if (next_count == 8'h00)
                on_live <= on_pending;
            pulse <= (on_eff > period) || (next_count < on_eff);
        end
    end

endmodule
`default_nettype wire

// ==== hdl/dspw_top.v ====
/*
 * Dual secondary pulse-width timers with an Avalon-MM register slave.
 * Assumes a single 125 MHz clock CLK and an Avalon-MM master that
 * holds each request until waitrequest is seen low.
 */
// Implementation choices: the register addresses and the Avalon-MM register port.
// Summary of operation
// - two 8-bit pulse outputs with period, on-time
// - mode bit 8: set independent, clear offset
// - all counts step once per two clocks
// - first period is 2*(first_period+1) clocks
// - second period 2*(second value+1), independent mode
// - on-time is 2*on-time value clocks
// - on-time above period holds output high
// - offset mode shares first period, own on-times
// - second rise lags first by 2*(value+1)
// - writes accepted anytime, no busy state
// - new on-time applies at next cycle start
// - period write clears timers, restarts cycles
// - reset clears mode bit: offset mode
// - reset periods 0xFF, on-times 0x00
`timescale 1ns/1ps
`default_nettype none
`include "dspw_consts.vh"

module dspw_top
(
    // clock and reset
    input  wire        CLK,
    input  wire        NRST,
    // avalon-mm timer registers
    input  wire [3:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [31:0] AVS_WRITEDATA,
    input  wire [3:0]  AVS_BYTEENABLE,
    output reg  [31:0] AVS_READDATA,
    output reg         AVS_WAITREQUEST,
    // avalon-mm shared mode control register
    input  wire        MODE_CS,
    // pulse outputs
    output reg         FIRST_PULSE_OUT,
    output reg         SECOND_PULSE_OUT
);

    ////////////////////////////////////////////////////////////////////
    // registers

    reg  [7:0] first_period;
    reg  [7:0] second_period_or_offset;
    reg  [7:0] first_on_time;
    reg  [7:0] second_on_time;
    reg        indep_mode;
    reg        restart;

    wire       req    = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    wire       wr_acc = AVS_WRITE && !AVS_WAITREQUEST;
    wire       tim_wr = wr_acc && !MODE_CS;
    wire       mod_wr = wr_acc && MODE_CS;

    // one wait cycle per access; the write lands on the acknowledging
    // edge, so a master that holds its request sees it exactly once
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            AVS_WAITREQUEST <= 1'b1;
        else
            AVS_WAITREQUEST <= !req;
    end

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            first_period            <= `DSPW_RST_PERIOD;
            second_period_or_offset <= `DSPW_RST_PERIOD;
            first_on_time           <= `DSPW_RST_ON_TIME;
            second_on_time          <= `DSPW_RST_ON_TIME;
            indep_mode              <= `DSPW_RST_MODE;
            restart                 <= 1'b0;
            AVS_READDATA            <= 32'h00000000;
        end
        else
        begin
            restart <= 1'b0;
            if (tim_wr && AVS_BYTEENABLE[0])
            begin
                case (AVS_ADDRESS)
                    `DSPW_OFS_FIRST_PERIOD:
                    begin
                        first_period <= AVS_WRITEDATA[7:0];
                        restart      <= 1'b1;
                    end
                    `DSPW_OFS_SECOND_PER:
                    begin
                        second_period_or_offset <= AVS_WRITEDATA[7:0];
                        restart                 <= 1'b1;
                    end
                    `DSPW_OFS_FIRST_ON:  first_on_time  <= AVS_WRITEDATA[7:0];
                    `DSPW_OFS_SECOND_ON: second_on_time <= AVS_WRITEDATA[7:0];
                    default: ;
                endcase
            end
            if (mod_wr && AVS_ADDRESS == `DSPW_OFS_MODE_CTRL && AVS_BYTEENABLE[1])
                indep_mode <= AVS_WRITEDATA[`DSPW_MODE_BIT];
            if (AVS_READ && AVS_WAITREQUEST)
            begin
                AVS_READDATA <= 32'h00000000;
                if (MODE_CS)
                begin
                    if (AVS_ADDRESS == `DSPW_OFS_MODE_CTRL)
                        AVS_READDATA[`DSPW_MODE_BIT] <= indep_mode;
                end
                else
                begin
                    case (AVS_ADDRESS)
                        `DSPW_OFS_FIRST_PERIOD: AVS_READDATA[7:0] <= first_period;
                        `DSPW_OFS_SECOND_PER:   AVS_READDATA[7:0] <= second_period_or_offset;
                        `DSPW_OFS_FIRST_ON:     AVS_READDATA[7:0] <= first_on_time;
                        `DSPW_OFS_SECOND_ON:    AVS_READDATA[7:0] <= second_on_time;
                        default:                AVS_READDATA      <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timebase and channels

    wire       tick;
    wire [7:0] count_a;
    wire [7:0] count_b;
    wire       pulse_a;
    wire       pulse_b;
    reg  [8:0] ofs_cnt;
    // start on a tick edge so the late channel stays on the timebase
    wire       ofs_hit = tick && (ofs_cnt == {1'b0, second_period_or_offset});

    dspw_tick u_tick
    (
        .clk     (CLK),
        .nrst    (NRST),
        .restart (restart),
        .tick    (tick)
    );

    // first channel always on its own period
    dspw_chan u_first
    (
        .clk        (CLK),
        .nrst       (NRST),
        .tick       (tick),
        .restart    (restart),
        .hold       (1'b0),
        .start      (1'b1),
        .period     (first_period),
        .on_pending (first_on_time),
        .count      (count_a),
        .pulse      (pulse_a)
    );

    // offset mode: shared period, late start; independent: own period
    dspw_chan u_second
    (
        .clk        (CLK),
        .nrst       (NRST),
        .tick       (tick),
        .restart    (restart),
        .hold       (1'b0),
        .start      (indep_mode ? 1'b1 : ofs_hit),
        .period     (indep_mode ? second_period_or_offset : first_period),
        .on_pending (second_on_time),
        .count      (count_b),
        .pulse      (pulse_b)
    );

    // offset point: 2*(value+1) clocks after first cycle start
    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            ofs_cnt <= 9'h000;
        else if (restart)
            ofs_cnt <= 9'h000;
        else if (tick && ofs_cnt <= {1'b0, second_period_or_offset})
            ofs_cnt <= ofs_cnt + 9'h001;
    end

    ////////////////////////////////////////////////////////////////////
    // outputs

    always @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            FIRST_PULSE_OUT  <= 1'b0;
            SECOND_PULSE_OUT <= 1'b0;
        end
        else
        begin
            FIRST_PULSE_OUT  <= pulse_a;
            SECOND_PULSE_OUT <= pulse_b;
        end
    end

endmodule
`default_nettype wire

// ==== sim/dspw_gate_load.sv ====
/* Load model on one pulse pin: measures high time, period and last
   rise in clock cycles. Shares clock and reset with the timers. */
`timescale 1ns/1ps
`default_nettype none
module dspw_gate_load
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // pin and figures
    input  wire logic pulse,
    output var  int   high_len,
    output var  int   per_len,
    output var  int   rise_at
);
    int   cyc;
    logic last;
    // one counter per load, both cleared by reset, so rises compare
    always @(posedge clk or negedge nrst)
        if (!nrst)
        begin
            cyc <= 0;
            last <= 1'b0;
            rise_at <= 0;
        end
        else
        begin
            cyc <= cyc + 1;
            last <= pulse;
            if (pulse && !last)
            begin
                per_len <= cyc - rise_at;
                rise_at <= cyc;
            end
            if (!pulse && last)
                high_len <= cyc - rise_at;
        end
endmodule
`default_nettype wire

// ==== sim/dspw_monitor.sv ====
/* Checker for the pulse timers: bus answer, readback, pulse steps and
   duty extremes. Bound to dspw_top, sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module dspw_monitor
(
    // clock, reset, bus
    input wire logic        CLK,
    input wire logic        NRST,
    input wire logic [3:0]  AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0]  AVS_BYTEENABLE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        MODE_CS,
    // pins
    input wire logic        FIRST_PULSE_OUT,
    input wire logic        SECOND_PULSE_OUT
);
    logic [7:0] regs [4];
    logic       mode;
    logic [9:0] quiet;
    wire        taken = AVS_WRITE && !AVS_WAITREQUEST;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////
    // shadow registers; quiet waits out one slowest period plus latch
    always @(posedge CLK or negedge NRST)
        if (!NRST)
        begin
            regs <= '{8'hFF, 8'hFF, 8'h00, 8'h00};
            mode <= 1'b0;
            quiet <= 10'h000;
        end
        else
        begin
            quiet <= taken ? 10'h000 : quiet + {9'h000, quiet != 10'h3FF};
            if (taken && MODE_CS && AVS_BYTEENABLE[1] && AVS_ADDRESS == 4'h0)
                mode <= AVS_WRITEDATA[8];
            if (taken && !MODE_CS && AVS_BYTEENABLE[0] && AVS_ADDRESS[1:0] == 2'h0)
                regs[AVS_ADDRESS[3:2]] <= AVS_WRITEDATA[7:0];
        end
    ////////////////////////////////////////////////////////////////////////
    a_wait_bound: assert property ((AVS_READ || AVS_WRITE) |-> ##[0:2] !AVS_WAITREQUEST)
        else $error("bus request not answered");
    a_first_step: assert property (($changed(FIRST_PULSE_OUT) && !AVS_WRITE && !$past(AVS_WRITE)
        && !$past(AVS_WRITE, 2) && !$past(AVS_WRITE, 3)) |=> $stable(FIRST_PULSE_OUT))
        else $error("first pin changed twice in a row");
    a_second_step: assert property (($changed(SECOND_PULSE_OUT) && !AVS_WRITE && !$past(AVS_WRITE)
        && !$past(AVS_WRITE, 2) && !$past(AVS_WRITE, 3)) |=> $stable(SECOND_PULSE_OUT))
        else $error("second pin changed twice in a row");
    a_reset_quiet: assert property ($rose(NRST) |-> (!FIRST_PULSE_OUT && !SECOND_PULSE_OUT)[*8])
        else $error("pin active after reset");
    a_read_mode: assert property ((AVS_READ && MODE_CS && AVS_ADDRESS == 4'h0 && !AVS_WAITREQUEST)
        |-> AVS_READDATA == {23'h0, mode, 8'h00})
        else $error("mode readback wrong");
    a_read_regs: assert property ((AVS_READ && !MODE_CS && AVS_ADDRESS[1:0] == 2'h0
        && !AVS_WAITREQUEST) |-> AVS_READDATA == {24'h0, regs[AVS_ADDRESS[3:2]]})
        else $error("timer readback wrong");
    a_full_first: assert property ((quiet > 10'h258 && regs[2] > regs[0]) |-> FIRST_PULSE_OUT)
        else $error("first pin not held on");
    a_zero_first: assert property ((quiet > 10'h258 && regs[2] == 8'h00) |-> !FIRST_PULSE_OUT)
        else $error("first pin on at zero duty");
    c_write: cover property (taken);
    c_offset: cover property (!mode && $rose(SECOND_PULSE_OUT));
    c_full: cover property (quiet > 10'h258 && regs[2] > regs[0] && FIRST_PULSE_OUT);
endmodule
bind dspw_top dspw_monitor dspw_monitor_inst (.CLK, .NRST, .AVS_ADDRESS, .AVS_READ,
    .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .MODE_CS, .FIRST_PULSE_OUT, .SECOND_PULSE_OUT);
`default_nettype wire

// ==== sim/test_dual_secondary_pwm_timers.sv ====
/* Testbench for the pulse timers: reset values, both modes, pending
   on-time. Assumes design, load model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module test_dual_secondary_pwm_timers;
    logic        CLK = 1'b0;
    logic        NRST = 1'b0;
    logic [3:0]  AVS_ADDRESS = 4'h0;
    logic        AVS_READ = 1'b0;
    logic        AVS_WRITE = 1'b0;
    logic [31:0] AVS_WRITEDATA = 32'h0;
    logic [3:0]  AVS_BYTEENABLE = 4'hF;
    logic        MODE_CS = 1'b0;
    logic [31:0] AVS_READDATA;
    logic        AVS_WAITREQUEST;
    logic        FIRST_PULSE_OUT;
    logic        SECOND_PULSE_OUT;
    int          fh, fp, fr, sh, sp, sr;
    int          fails = 0;
    int          checks = 0;
    logic [31:0] q, v;
    dspw_top dspw_top_inst (.CLK, .NRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
        .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .MODE_CS, .FIRST_PULSE_OUT,
        .SECOND_PULSE_OUT);
    dspw_gate_load first_load (.clk(CLK), .nrst(NRST), .pulse(FIRST_PULSE_OUT),
        .high_len(fh), .per_len(fp), .rise_at(fr));
    dspw_gate_load second_load (.clk(CLK), .nrst(NRST), .pulse(SECOND_PULSE_OUT),
        .high_len(sh), .per_len(sp), .rise_at(sr));
    initial
    begin
        forever #4 CLK = ~CLK;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
        checks++;
        if (seen !== expd)
        begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    // one access, then an idle edge: the slave takes one every two cycles
    task automatic bus(input logic cs, input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        MODE_CS <= cs;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= w;
        AVS_READ <= !w;
        do
        begin
            @(posedge CLK);
            n++;
        end
        while (AVS_WAITREQUEST !== 1'b0 && n < 20);
        if (n == 20)
            chk({31'h0, AVS_WAITREQUEST}, 32'h0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'b0;
        AVS_READ <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic meas(input logic o, input int hl, input int pl, input logic [7:0] p,
        input logic [7:0] c);
        if (c == 8'h00)
            chk({31'h0, o}, 32'h0);
        else if (c > p)
            chk({31'h0, o}, 32'h1);
        else
        begin
            chk(hl, 2 * c);
            chk(pl, 2 * (p + 1));
        end
    endtask
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (40000) @(posedge CLK);
        fails++;
        end_sim;
    end
    initial
    begin
        v = $urandom(32'h67d3);
        repeat (10) @(posedge CLK);
        NRST <= 1'b1;
        @(posedge CLK);
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, 1'b0, 4'(i * 4), 32'h0);
            chk(q, i < 2 ? 32'hFF : 32'h00);
        end
        bus(1'b1, 1'b0, 4'h0, 32'h0);
        chk(q, 32'h0);
        $display("test reset values done");
        bus(1'b1, 1'b1, 4'h0, 32'h100);
        for (int i = 0; i < 6; i++)
        begin
            v = i == 0 ? 32'h0001FF00 : i == 1 ? 32'hFFFF0101 : $urandom;
            bus(1'b0, 1'b1, 4'h8, {24'h0, v[23:16]});
            bus(1'b0, 1'b1, 4'hC, {24'h0, v[7:0]});
            bus(1'b0, 1'b1, 4'h0, {24'h0, v[31:24]});
            bus(1'b0, 1'b1, 4'h4, {24'h0, v[15:8]});
            bus(1'b0, 1'b0, 4'h0, 32'h0);
            chk(q, {24'h0, v[31:24]});
            repeat (1100) @(posedge CLK);
            meas(FIRST_PULSE_OUT, fh, fp, v[31:24], v[23:16]);
            meas(SECOND_PULSE_OUT, sh, sp, v[15:8], v[7:0]);
        end
        $display("test independent mode done");
        bus(1'b0, 1'b1, 4'h8, 32'h0);
        bus(1'b0, 1'b1, 4'h0, 32'hFF);
        bus(1'b0, 1'b1, 4'h8, 32'h10);
        wait (FIRST_PULSE_OUT);
        @(posedge CLK);
        bus(1'b0, 1'b1, 4'h8, 32'h30);
        wait (!FIRST_PULSE_OUT);
        repeat (2) @(posedge CLK);
        chk(fh, 32'h20);
        wait (FIRST_PULSE_OUT);
        wait (!FIRST_PULSE_OUT);
        repeat (2) @(posedge CLK);
        chk(fh, 32'h60);
        $display("test pending on-time done");
        bus(1'b1, 1'b1, 4'h0, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            v[31:24] = 8'h20 + 8'($urandom % 200);
            v[15:8] = 8'($urandom % v[31:24]);
            v[23:16] = 8'(1 + $urandom % v[31:24]);
            bus(1'b0, 1'b1, 4'h8, {24'h0, v[23:16]});
            bus(1'b0, 1'b1, 4'hC, {24'h0, v[23:16]});
            bus(1'b0, 1'b1, 4'h4, {24'h0, v[15:8]});
            bus(1'b0, 1'b1, 4'h0, {24'h0, v[31:24]});
            repeat (1100) @(posedge CLK);
            chk(sp, 2 * (v[31:24] + 1));
            chk((sr - fr + fp) % fp, 2 * (v[15:8] + 1));
        end
        $display("test offset mode done");
        end_sim;
    end
endmodule
`default_nettype wire
